//--- inc/dtbmi_pkg.sv
// constants, types and helpers for the data-lane termination and mask/invert block
package dtbmi_pkg;

  // register byte addresses
  localparam logic [4:0] ADDR_MODE_REG_THREE    = 5'h0_0;
  localparam logic [4:0] ADDR_MODE_REG_ELEVEN   = 5'h0_4;
  localparam logic [4:0] ADDR_MODE_REG_THIRTEEN = 5'h0_8;
  localparam logic [4:0] ADDR_LANE_CONFIG       = 5'h0_C;
  localparam logic [4:0] ADDR_LANE_STATUS       = 5'h1_0;

  // field positions
  localparam int READ_INV_BIT   = 6;
  localparam int WRITE_INV_BIT  = 7;
  localparam int MASK_EN_BIT    = 5;
  localparam int STRENGTH_LSB   = 0;
  localparam int STRENGTH_W     = 3;
  localparam int BAND_LSB       = 0;
  localparam int LAT_SET_B_BIT  = 3;
  localparam int PRE_TWO_BIT    = 4;
  localparam int BURST_32_BIT   = 5;

  // reset values
  localparam logic [7:0] MODE_REG_THREE_RST    = 8'h0_0;
  localparam logic [7:0] MODE_REG_ELEVEN_RST   = 8'h0_0;
  localparam logic [7:0] MODE_REG_THIRTEEN_RST = 8'h0_0;
  localparam logic [7:0] LANE_CONFIG_RST       = 8'h0_3;

  // timing: core clock and analog windows
  localparam int CORE_PERIOD_PS     = 20000;
  localparam int TERM_RISE_MIN_PS   = 1500;
  localparam int TERM_RISE_MAX_PS   = 3500;
  localparam int TERM_FALL_MIN_PS   = 1500;
  localparam int TERM_FALL_MAX_PS   = 3500;
  localparam int RISE_MIN_CYC  = (TERM_RISE_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int RISE_MAX_CYC  = TERM_RISE_MAX_PS / CORE_PERIOD_PS;
  localparam int TERM_RISE_CYC = (RISE_MIN_CYC > RISE_MAX_CYC) ? RISE_MIN_CYC :
                                 ((RISE_MAX_CYC < 1) ? 1 : RISE_MAX_CYC);
  localparam int FALL_MIN_CYC  = (TERM_FALL_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int FALL_MAX_CYC  = TERM_FALL_MAX_PS / CORE_PERIOD_PS;
  localparam int TERM_FALL_CYC = (FALL_MIN_CYC > FALL_MAX_CYC) ? FALL_MIN_CYC :
                                 ((FALL_MAX_CYC < 1) ? 1 : FALL_MAX_CYC);

  // latencies in link clocks per band; zero marks a band without termination
  localparam logic [5:0] BURST_32_EXTRA = 6'h0_8;
  localparam logic [5:0] ON_PRE1_A [8] = '{6'h00, 6'h00, 6'h04, 6'h04, 6'h06, 6'h06, 6'h08, 6'h08};
  localparam logic [5:0] ON_PRE1_B [8] = '{6'h00, 6'h00, 6'h08, 6'h0C, 6'h10, 6'h12, 6'h16, 6'h18};
  localparam logic [5:0] ON_PRE2_A [8] = '{6'h00, 6'h00, 6'h00, 6'h04, 6'h04, 6'h06, 6'h06, 6'h08};
  localparam logic [5:0] ON_PRE2_B [8] = '{6'h00, 6'h00, 6'h06, 6'h0C, 6'h0E, 6'h12, 6'h14, 6'h18};
  localparam logic [5:0] OFF_SET_A [8] = '{6'h00, 6'h00, 6'h12, 6'h14, 6'h16, 6'h18, 6'h1A, 6'h1C};
  localparam logic [5:0] OFF_SET_B [8] = '{6'h00, 6'h00, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28, 6'h2C};

  typedef enum logic [2:0] {
    CMD_NONE, CMD_WRITE, CMD_MASK_WRITE, CMD_FIFO_WRITE,
    CMD_READ, CMD_MODE_READ, CMD_MODE_WRITE, CMD_FIFO_READ
  } dtbmi_cmd_type;

  typedef enum logic [2:0] {
    TERM_IDLE, TERM_WAIT_ON, TERM_RISE, TERM_ON, TERM_FALL
  } dtbmi_term_type;

  // everything that arrives on pins from the controller
  typedef struct packed {
    logic          link_clk;
    logic          clk_enable;
    logic          power_down;
    logic          self_refresh;
    logic          write_level;
    logic          cmd_strobe;
    dtbmi_cmd_type cmd_kind;
    logic          beat_valid;
    logic [15:0]   dq;
    logic [1:0]    mask_invert_pin;
  } dtbmi_pin_type;

  function automatic logic [3:0] dtbmi_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction : dtbmi_ones

endpackage : dtbmi_pkg

//--- hdl/dtbmi_lane.sv
// data-lane termination timing and byte mask/invert handling
`timescale 1ns/10ps
module dtbmi_lane
  import dtbmi_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // register port
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WRITE,
  input  wire logic        REG_READ,
  output logic      [7:0]  REG_RDATA,
  // pins from the controller
  input  wire logic        LINK_CLK,
  input  wire logic        CLK_ENABLE,
  input  wire logic        POWER_DOWN,
  input  wire logic        SELF_REFRESH,
  input  wire logic        WRITE_LEVEL,
  input  wire logic        CMD_STROBE,
  input  wire logic [2:0]  CMD_KIND,
  input  wire logic        BEAT_VALID,
  input  wire logic [15:0] DQ_IN,
  output logic      [15:0] DQ_OUT,
  output logic             DQ_OE,
  input  wire logic [1:0]  MI_IN,
  output logic      [1:0]  MI_OUT,
  output logic             MI_OE,
  output logic             MI_RX_EN,
  // termination switches
  output logic             TERM_DQ,
  output logic             TERM_DQS,
  output logic             TERM_MI,
  // array side
  output logic      [15:0] WR_DATA,
  output logic      [1:0]  WR_BYTE_EN,
  output logic             WR_VALID,
  output logic      [1:0]  TRAIN_BIT,
  output logic             TRAIN_VALID,
  input  wire logic        RD_VALID,
  input  wire logic        RD_IS_FIFO,
  input  wire logic [15:0] RD_DATA,
  input  wire logic [1:0]  RD_TRAIN_BIT
);

  dtbmi_pin_type  pin_raw;
  dtbmi_pin_type  pin_meta;
  dtbmi_pin_type  pin_sync;
  logic           link_last;
  logic           link_rise;
  logic [7:0]     mode_reg_three;
  logic [7:0]     mode_reg_eleven;
  logic [7:0]     mode_reg_thirteen;
  logic [7:0]     lane_config;
  logic           read_inv;
  logic           write_inv;
  logic           mask_en;
  logic           any_func;
  logic           term_allowed;
  logic [2:0]     band;
  logic [5:0]     on_lat;
  logic [5:0]     off_lat;
  logic           cmd_go;
  logic           term_start;
  dtbmi_cmd_type  wr_kind;
  dtbmi_term_type state;
  dtbmi_term_type next_state;
  logic [5:0]     on_cnt;
  logic [5:0]     off_cnt;
  logic [2:0]     win_cnt;
  logic           on_expire;
  logic           off_expire;
  logic           beat_go;
  logic [15:0]    next_wr_data;
  logic [1:0]     next_byte_en;
  logic [15:0]    next_dq_out;
  logic [1:0]     next_mi_out;

  assign pin_raw = '{LINK_CLK, CLK_ENABLE, POWER_DOWN, SELF_REFRESH, WRITE_LEVEL,
                     CMD_STROBE, dtbmi_cmd_type'(CMD_KIND), BEAT_VALID, DQ_IN, MI_IN};

  // two flops before any logic looks at a pin
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      link_last <= 1'b0;
    end else begin
      pin_meta  <= pin_raw;
      pin_sync  <= pin_meta;
      link_last <= pin_sync.link_clk;
    end
  end

  assign link_rise = pin_sync.link_clk && !link_last;

  // register writes
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      mode_reg_three    <= MODE_REG_THREE_RST;
      mode_reg_eleven   <= MODE_REG_ELEVEN_RST;
      mode_reg_thirteen <= MODE_REG_THIRTEEN_RST;
      lane_config       <= LANE_CONFIG_RST;
    end else if (REG_WRITE) begin
      unique case (REG_ADDR)
        ADDR_MODE_REG_THREE:    mode_reg_three    <= REG_WDATA;
        ADDR_MODE_REG_ELEVEN:   mode_reg_eleven   <= REG_WDATA;
        ADDR_MODE_REG_THIRTEEN: mode_reg_thirteen <= REG_WDATA;
        ADDR_LANE_CONFIG:       lane_config       <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe, zero elsewhere
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h0_0;
    end else if (REG_READ) begin
      unique case (REG_ADDR)
        ADDR_MODE_REG_THREE:    REG_RDATA <= mode_reg_three;
        ADDR_MODE_REG_ELEVEN:   REG_RDATA <= mode_reg_eleven;
        ADDR_MODE_REG_THIRTEEN: REG_RDATA <= mode_reg_thirteen;
        ADDR_LANE_CONFIG:       REG_RDATA <= lane_config;
        ADDR_LANE_STATUS:       REG_RDATA <= {TERM_DQS, TERM_DQ, term_allowed, 2'b00, state};
        default:                REG_RDATA <= 8'h0_0;
      endcase
    end else begin
      REG_RDATA <= 8'h0_0;
    end
  end

  assign read_inv  = mode_reg_three[READ_INV_BIT];
  assign write_inv = mode_reg_three[WRITE_INV_BIT];
  assign mask_en   = mode_reg_thirteen[MASK_EN_BIT];
  assign any_func  = read_inv || write_inv || mask_en;

  // strength, power-down and self refresh with clock enable low gate the switch
  assign term_allowed = (mode_reg_eleven[STRENGTH_LSB +: STRENGTH_W] != 3'b000)
                        && !pin_sync.power_down
                        && !(pin_sync.self_refresh && !pin_sync.clk_enable);

  // latency lookup
  assign band = lane_config[BAND_LSB +: 3];
  always_comb begin
    if (lane_config[PRE_TWO_BIT]) begin
      on_lat = lane_config[LAT_SET_B_BIT] ? ON_PRE2_B[band] : ON_PRE2_A[band];
    end else begin
      on_lat = lane_config[LAT_SET_B_BIT] ? ON_PRE1_B[band] : ON_PRE1_A[band];
    end
    off_lat = lane_config[LAT_SET_B_BIT] ? OFF_SET_B[band] : OFF_SET_A[band];
    if (lane_config[BURST_32_BIT] && off_lat != 6'h0_0) begin
      off_lat = off_lat + BURST_32_EXTRA;
    end
  end

  // command edge is the second command cycle; only writes that carry data start
  assign cmd_go     = link_rise && pin_sync.cmd_strobe;
  assign term_start = cmd_go && on_lat != 6'h0_0 && (pin_sync.cmd_kind == CMD_WRITE
                      || pin_sync.cmd_kind == CMD_MASK_WRITE
                      || pin_sync.cmd_kind == CMD_FIFO_WRITE);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      wr_kind <= CMD_NONE;
    end else if (cmd_go) begin
      wr_kind <= pin_sync.cmd_kind;
    end
  end

  // latency counters tick on link edges only
  assign on_expire  = link_rise && on_cnt == 6'h0_1;
  assign off_expire = link_rise && off_cnt == 6'h0_1;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      on_cnt <= 6'h0_0;
    end else if (term_start && (state == TERM_IDLE || state == TERM_FALL)) begin
      on_cnt <= on_lat;
    end else if (link_rise && on_cnt != 6'h0_0) begin
      on_cnt <= on_cnt - 6'h0_1;
    end
  end

  // a later write extends the burst, so the off count restarts
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      off_cnt <= 6'h0_0;
    end else if (term_start) begin
      off_cnt <= off_lat;
    end else if (link_rise && off_cnt != 6'h0_0) begin
      off_cnt <= off_cnt - 6'h0_1;
    end
  end

  // analog window counter; both windows fit in one core cycle at this rate
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      win_cnt <= 3'h0;
    end else if (state != next_state) begin
      win_cnt <= 3'h0;
    end else if (win_cnt != 3'h7) begin
      win_cnt <= win_cnt + 3'h1;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      TERM_IDLE:    if (term_start) next_state = TERM_WAIT_ON;
      TERM_WAIT_ON: if (on_expire) next_state = TERM_RISE;
      TERM_RISE: begin
        if (win_cnt == 3'(TERM_RISE_CYC - 1)) next_state = TERM_ON;
      end
      TERM_ON:      if (off_expire) next_state = TERM_FALL;
      TERM_FALL: begin
        if (term_start) next_state = TERM_WAIT_ON;
        else if (win_cnt == 3'(TERM_FALL_CYC - 1)) next_state = TERM_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state <= TERM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // switches; write leveling keeps data and mask lanes open
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      TERM_DQ  <= 1'b0;
      TERM_MI  <= 1'b0;
      TERM_DQS <= 1'b0;
    end else begin
      TERM_DQ  <= term_allowed && !pin_sync.write_level
                  && (state == TERM_ON || state == TERM_FALL);
      TERM_MI  <= term_allowed && !pin_sync.write_level
                  && (state == TERM_ON || state == TERM_FALL);
      TERM_DQS <= term_allowed && (pin_sync.write_level
                  || state == TERM_ON || state == TERM_FALL);
    end
  end

  // write beats, each byte on its own pin
  assign beat_go = link_rise && pin_sync.beat_valid;

  for (genvar b = 0; b < 2; b++) begin : g_wbyte
    logic [7:0] d;
    logic       m;
    logic [3:0] upper_ones;
    assign d          = pin_sync.dq[b*8 +: 8];
    assign m          = pin_sync.mask_invert_pin[b];
    assign upper_ones = dtbmi_ones({d[7:2], 2'b00});
    always_comb begin
      next_wr_data[b*8 +: 8] = d;
      next_byte_en[b]        = 1'b1;
      unique case (wr_kind)
        CMD_MASK_WRITE: begin
          if (mask_en && write_inv) begin
            if (!m && upper_ones >= 4'h5) next_byte_en[b] = 1'b0;
            else if (m) next_wr_data[b*8 +: 8] = ~d;
          end else if (mask_en) begin
            next_byte_en[b] = !m;
          end else if (write_inv && m) begin
            next_wr_data[b*8 +: 8] = ~d;
          end
        end
        CMD_WRITE, CMD_MODE_WRITE: begin
          if (write_inv && m) next_wr_data[b*8 +: 8] = ~d;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      WR_DATA     <= 16'h0000;
      WR_BYTE_EN  <= 2'b00;
      WR_VALID    <= 1'b0;
      TRAIN_BIT   <= 2'b00;
      TRAIN_VALID <= 1'b0;
    end else begin
      WR_VALID    <= beat_go && wr_kind != CMD_FIFO_WRITE;
      TRAIN_VALID <= beat_go && wr_kind == CMD_FIFO_WRITE;
      if (beat_go) begin
        WR_DATA    <= (wr_kind == CMD_FIFO_WRITE) ? pin_sync.dq : next_wr_data;
        WR_BYTE_EN <= (wr_kind == CMD_FIFO_WRITE) ? 2'b11 : next_byte_en;
        TRAIN_BIT  <= any_func ? pin_sync.mask_invert_pin : 2'b00;
      end
    end
  end

  // receivers only while the pin carries meaning for the current write
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      MI_RX_EN <= 1'b0;
    end else begin
      unique case (wr_kind)
        CMD_WRITE, CMD_MODE_WRITE: MI_RX_EN <= write_inv;
        CMD_MASK_WRITE:            MI_RX_EN <= mask_en || write_inv;
        CMD_FIFO_WRITE:            MI_RX_EN <= any_func;
        default:                   MI_RX_EN <= 1'b0;
      endcase
    end
  end

  // read path, per byte
  for (genvar b = 0; b < 2; b++) begin : g_rbyte
    logic [7:0] d;
    assign d = RD_DATA[b*8 +: 8];
    always_comb begin
      if (RD_IS_FIFO) begin
        next_dq_out[b*8 +: 8] = d;
        next_mi_out[b]        = RD_TRAIN_BIT[b];
      end else if (read_inv && dtbmi_ones(d) > 4'h4) begin
        next_dq_out[b*8 +: 8] = ~d;
        next_mi_out[b]        = 1'b1;
      end else begin
        next_dq_out[b*8 +: 8] = d;
        next_mi_out[b]        = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      DQ_OUT <= 16'h0000;
      DQ_OE  <= 1'b0;
      MI_OUT <= 2'b00;
      MI_OE  <= 1'b0;
    end else begin
      DQ_OE <= RD_VALID;
      MI_OE <= RD_VALID && (RD_IS_FIFO ? any_func : read_inv);
      if (RD_VALID) begin
        DQ_OUT <= next_dq_out;
        MI_OUT <= next_mi_out;
      end
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rise_step;
    state == TERM_RISE ##1 state == TERM_ON;
  endsequence
  sequence s_fall_step;
    state == TERM_FALL ##1 state != TERM_ON;
  endsequence

  property p_on_expire;
    state == TERM_WAIT_ON && on_expire |=> s_rise_step;
  endproperty
  a_on_expire: assert property (p_on_expire) else $error("late turn-on");

  property p_off_expire;
    state == TERM_ON && off_expire |=> s_fall_step;
  endproperty
  a_off_expire: assert property (p_off_expire) else $error("late turn-off");

  property p_on_load;
    term_start && state == TERM_IDLE |=> on_cnt == $past(on_lat);
  endproperty
  a_on_load: assert property (p_on_load) else $error("turn-on latency not loaded");

  property p_off_burst;
    term_start && lane_config[BURST_32_BIT]
      |=> off_cnt == $past((lane_config[LAT_SET_B_BIT] ? OFF_SET_B[band] : OFF_SET_A[band])
                           + BURST_32_EXTRA);
  endproperty
  a_off_burst: assert property (p_off_burst) else $error("turn-off latency wrong");

  property p_power_down;
    pin_sync.power_down |=> !TERM_DQ && !TERM_DQS && !TERM_MI;
  endproperty
  a_power_down: assert property (p_power_down) else $error("termination in power-down");

  property p_self_refresh;
    pin_sync.self_refresh && !pin_sync.clk_enable |=> !TERM_DQ && !TERM_DQS;
  endproperty
  a_self_refresh: assert property (p_self_refresh) else $error("termination with cke low");

  property p_write_level;
    pin_sync.write_level && term_allowed |=> TERM_DQS && !TERM_DQ && !TERM_MI;
  endproperty
  a_write_level: assert property (p_write_level) else $error("write leveling termination");

  property p_strength_zero;
    mode_reg_eleven[2:0] == 3'b000 |=> !TERM_DQ && !TERM_DQS;
  endproperty
  a_strength_zero: assert property (p_strength_zero) else $error("termination at zero");

  property p_read_inv;
    RD_VALID && !RD_IS_FIFO && read_inv && dtbmi_ones(RD_DATA[7:0]) > 4'h4
      |=> MI_OUT[0] && DQ_OUT[7:0] == ~$past(RD_DATA[7:0]) && MI_OE;
  endproperty
  a_read_inv: assert property (p_read_inv) else $error("read byte not inverted");

  property p_mi_quiet;
    RD_VALID && !RD_IS_FIFO && !read_inv |=> !MI_OE;
  endproperty
  a_mi_quiet: assert property (p_mi_quiet) else $error("mask pin driven");

  property p_mask_beat;
    beat_go && wr_kind == CMD_MASK_WRITE && mask_en && !write_inv && pin_sync.mask_invert_pin[0]
      |=> WR_VALID && !WR_BYTE_EN[0];
  endproperty
  a_mask_beat: assert property (p_mask_beat) else $error("masked beat written");

  property p_plain_write;
    beat_go && wr_kind == CMD_WRITE && !write_inv
      |=> WR_BYTE_EN == 2'b11 && WR_DATA == $past(pin_sync.dq);
  endproperty
  a_plain_write: assert property (p_plain_write) else $error("plain write altered");

endmodule : dtbmi_lane

//--- tb/dtbmi_ctrl_model.sv
// controller-side model: free-running command clock, commands and write beats
`timescale 1ns/10ps
module dtbmi_ctrl_model
  import dtbmi_pkg::*;
(
  output logic        link_clk,
  output logic        strobe,
  output logic [2:0]  kind,
  output logic        beat,
  output logic [15:0] dq,
  output logic [1:0]  mi
);
  initial begin
    {link_clk, strobe, kind, beat, dq, mi} = '0;
    forever #80 link_clk = ~link_clk;
  end
  // changes on the falling edge, held across the sampling rise
  task automatic send_cmd(input logic [2:0] k);
    @(negedge link_clk) {strobe, kind} <= {1'b1, k};
    @(negedge link_clk) {strobe, kind} <= '0;
  endtask : send_cmd
  task automatic send_beat(input logic [15:0] d, input logic [1:0] m);
    @(negedge link_clk) {beat, dq, mi} <= {1'b1, d, m};
  endtask : send_beat
  // released lines show the inverse so stale data cannot pass as fresh
  task automatic idle();
    @(negedge link_clk) {beat, dq, mi} <= {1'b0, ~dq, ~mi};
  endtask : idle
endmodule : dtbmi_ctrl_model

//--- tb/test_dq_termination_and_byte_mask_invert.sv
// self-checking bench for the termination and mask/invert lane
`timescale 1ns/10ps
module test_dq_termination_and_byte_mask_invert
  import dtbmi_pkg::*;
;
  logic CORE_CLK, RESET_N, REG_WRITE, REG_READ, CLK_ENABLE, POWER_DOWN, SELF_REFRESH;
  logic WRITE_LEVEL, DQ_OE, MI_OE, MI_RX_EN, TERM_DQ, TERM_DQS, TERM_MI, WR_VALID;
  logic TRAIN_VALID, RD_VALID, RD_IS_FIFO, LINK_CLK, CMD_STROBE, BEAT_VALID;
  logic [2:0]  CMD_KIND;
  logic [4:0]  REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA;
  logic [15:0] DQ_IN, DQ_OUT, WR_DATA, RD_DATA, m16;
  logic [1:0]  MI_IN, MI_OUT, WR_BYTE_EN, TRAIN_BIT, RD_TRAIN_BIT;
  logic [20:0] expq[$];
  logic [20:0] e;
  logic [31:0] seed = 32'h0000_3f80;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // write modes {mode_reg_three, mode_reg_thirteen, command}
  localparam logic [18:0] WMODES [5] = '{{8'h80, 8'h00, 3'h1}, {8'h00, 8'h20, 3'h1},
    {8'h00, 8'h20, 3'h2}, {8'hC0, 8'h20, 3'h2}, {8'h80, 8'h00, 3'h3}};

  dtbmi_lane uut (.CORE_CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ,
    .REG_RDATA, .LINK_CLK, .CLK_ENABLE, .POWER_DOWN, .SELF_REFRESH, .WRITE_LEVEL,
    .CMD_STROBE, .CMD_KIND, .BEAT_VALID, .DQ_IN, .DQ_OUT, .DQ_OE, .MI_IN, .MI_OUT, .MI_OE,
    .MI_RX_EN, .TERM_DQ, .TERM_DQS, .TERM_MI, .WR_DATA, .WR_BYTE_EN, .WR_VALID,
    .TRAIN_BIT, .TRAIN_VALID, .RD_VALID, .RD_IS_FIFO, .RD_DATA, .RD_TRAIN_BIT);
  dtbmi_ctrl_model ctrl (.link_clk(LINK_CLK), .strobe(CMD_STROBE), .kind(CMD_KIND),
    .beat(BEAT_VALID), .dq(DQ_IN), .mi(MI_IN));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // model entry {training, byte enables, pin, data}
  function automatic logic [20:0] wexp(input logic [2:0] k, input logic [7:0] m3,
                                       input logic [15:0] d, input logic [1:0] mi);
    logic [20:0] r;
    r = {k == 3'h3, 2'b11, mi, d};
    for (int b = 0; b < 2; b++) begin
      if (k == 3'h2 && !m3[7]) r[18+b] = !mi[b];
      else if (k == 3'h2 && !mi[b] && $countones(d[8*b+2+:6]) >= 5) r[18+b] = 1'b0;
      else if (k != 3'h3 && m3[7] && mi[b]) r[8*b+:8] = ~d[8*b+:8];
    end
    return r;
  endfunction : wexp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CORE_CLK) {REG_ADDR, REG_WDATA, REG_WRITE} <= {a, d, 1'b1};
    @(posedge CORE_CLK) REG_WRITE <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] x);
    @(posedge CORE_CLK) {REG_ADDR, REG_READ} <= {a, 1'b1};
    @(posedge CORE_CLK) REG_READ <= 1'b0;
    #1 chk(REG_RDATA, x);
  endtask : rd
  task automatic rdbeat(input logic inv);
    logic [15:0] d, x;
    logic [1:0]  t, m;
    logic        f;
    {d, t, f} = 19'(rnd());
    x = d;
    m = f ? t : 2'b00;
    for (int b = 0; b < 2; b++) begin
      if (!f && inv && $countones(d[8*b+:8]) > 4) {x[8*b+:8], m[b]} = {~d[8*b+:8], 1'b1};
    end
    @(posedge CORE_CLK) {RD_VALID, RD_DATA, RD_IS_FIFO, RD_TRAIN_BIT} <= {1'b1, d, f, t};
    @(posedge CORE_CLK) RD_VALID <= 1'b0;
    #1 chk({DQ_OE, MI_OE, DQ_OUT}, {1'b1, inv, x});
    chk(MI_OUT & {2{inv}}, m & {2{inv}});
  endtask : rdbeat
  // counts link rises from the command until the strobe pair turns on and off
  task automatic term(input logic [2:0] k, input int on, input int off, input logic dq);
    int n;
    // let any earlier burst run out before the count starts
    repeat (24) @(posedge LINK_CLK);
    ctrl.send_cmd(k);
    n = 0;
    while (TERM_DQS !== 1'b1 && n < 61) begin
      @(posedge LINK_CLK);
      n++;
    end
    // switch lands just after the expiring rise, seen one rise later
    chk(n - 1, on);
    chk({TERM_DQ, TERM_MI}, {dq, dq});
    if (on < 60) begin
      while (TERM_DQS === 1'b1 && n < 90) begin
        @(posedge LINK_CLK);
        n++;
      end
      chk(n - 1, off);
    end
  endtask : term
  task automatic conclude();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  always @(posedge CORE_CLK) begin
    if (WR_VALID === 1'b1 || TRAIN_VALID === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : '1;
      m16 = {{8{e[19]}}, {8{e[18]}}};
      if (e[20]) chk({TRAIN_VALID, TRAIN_BIT, WR_DATA}, {1'b1, e[17:0]});
      else chk({WR_VALID, WR_BYTE_EN, WR_DATA & m16}, {1'b1, e[19:18], e[15:0] & m16});
    end
  end
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #500us;
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [7:0]  m3, m13, c;
    logic [2:0]  k;
    logic [15:0] d;
    logic [1:0]  mi;
    {REG_WRITE, REG_READ, RD_VALID, RD_IS_FIFO, POWER_DOWN, SELF_REFRESH, WRITE_LEVEL} = '0;
    {CLK_ENABLE, RESET_N, REG_ADDR, REG_WDATA, RD_DATA, RD_TRAIN_BIT} = {2'b10, 31'h0};
    repeat (10) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    rd(ADDR_MODE_REG_THREE, MODE_REG_THREE_RST);
    rd(ADDR_LANE_CONFIG, LANE_CONFIG_RST);
    rd(5'h14, 8'h00);
    rd(ADDR_LANE_STATUS, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_MODE_REG_THREE, s ? 8'h40 : 8'h00);
      repeat (8) rdbeat(s[0]);
    end
    for (int j = 0; j < 5; j++) begin
      {m3, m13, k} = WMODES[j]; // never a masked write with masking off
      wr(ADDR_MODE_REG_THREE, m3);
      wr(ADDR_MODE_REG_THIRTEEN, m13);
      rd(ADDR_MODE_REG_THIRTEEN, m13);
      ctrl.send_cmd(k);
      for (int b = 0; b < 4; b++) begin
        {d, mi} = 18'(rnd()) | ((b == 0) ? 18'h3F3F0 : 18'h0);
        expq.push_back(wexp(k, m3, d, mi));
        ctrl.send_beat(d, mi);
      end
      ctrl.idle();
      chk(MI_RX_EN, (k == 3'h1) ? m3[7] : 1'b1);
      repeat (4) @(posedge LINK_CLK);
    end
    wr(ADDR_MODE_REG_THREE, 8'h00);
    wr(ADDR_MODE_REG_ELEVEN, 8'h01);
    for (int j = 0; j < 3; j++) begin
      c = (j == 0) ? 8'h03 : ((j == 1) ? 8'h0B : 8'h23);
      wr(ADDR_LANE_CONFIG, c);
      term(3'h1, c[3] ? ON_PRE1_B[c[2:0]] : ON_PRE1_A[c[2:0]],
           (c[3] ? OFF_SET_B[c[2:0]] : OFF_SET_A[c[2:0]]) + (c[5] ? 8 : 0),
           1'b1);
    end
    wr(ADDR_LANE_CONFIG, 8'h03);
    term(3'h4, 60, 0, 1'b0);
    // strobe pair stays terminated all through leveling, data lanes never
    @(posedge CORE_CLK) WRITE_LEVEL <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    #1 chk({TERM_DQS, TERM_DQ, TERM_MI}, 3'b100);
    ctrl.send_cmd(3'h1);
    repeat (8) @(posedge LINK_CLK);
    chk({TERM_DQS, TERM_DQ, TERM_MI}, 3'b100);
    repeat (20) @(posedge LINK_CLK);
    @(posedge CORE_CLK) WRITE_LEVEL <= 1'b0;
    POWER_DOWN <= 1'b1;
    term(3'h1, 60, 0, 1'b0);
    POWER_DOWN <= 1'b0;
    SELF_REFRESH <= 1'b1;
    CLK_ENABLE <= 1'b0;
    term(3'h1, 60, 0, 1'b0);
    CLK_ENABLE <= 1'b1;
    term(3'h1, 4, 20, 1'b1);
    SELF_REFRESH <= 1'b0;
    wr(ADDR_MODE_REG_ELEVEN, 8'h00);
    term(3'h1, 60, 0, 1'b0);
    chk(expq.size(), 0);
    conclude();
  end
endmodule : test_dq_termination_and_byte_mask_invert
